// ==== scs_pkg.sv ====
// Constants, field layout and state codes of the serial controller timing block
// ============================================================
package scs_pkg;

  // ============================================================
  // Clock
  localparam int CORE_CLK_NS = 10;
  localparam int MIN_SCLK_NS = 25;
  localparam int MIN_SCLK_CYC = (MIN_SCLK_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // ============================================================
  // Register fields
  localparam int CTRL_SEL_BIT = 0;
  localparam int FMT_PHASE_BIT = 16;
  localparam int FMT_POL_BIT = 17;
  localparam int FMT_PS_LSB = 8;
  localparam int FMT_PS_MSB = 15;
  localparam int FMT_LEN_LSB = 0;
  localparam int FMT_LEN_MSB = 4;
  localparam int DLY_C2T_LSB = 24;
  localparam int DLY_C2T_MSB = 31;
  localparam int DLY_T2C_LSB = 16;
  localparam int DLY_T2C_MSB = 23;

  // ============================================================
  // Word and timing figures
  localparam int WORD_W = 16;
  localparam logic [4:0] LEN_MIN = 5'h02;
  localparam logic [4:0] LEN_MAX = 5'h10;
  localparam logic [9:0] SETUP_ADD = 10'h002;
  localparam logic [9:0] SETUP_ADD_HOLD = 10'h003;
  localparam logic [9:0] DESEL_ADD = 10'h001;
  localparam logic [8:0] PS0_PERIOD = 9'h002;
  localparam int FIFO_W = WORD_W + 1;
  localparam int FIFO_D = 16;

  // ============================================================
  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_SHIFT = 5'h04,
    ST_HOLD = 5'h08,
    ST_KEEP = 5'h10
  } scs_state_e;

endpackage : scs_pkg

// ==== scs_fifo.sv ====
// Word FIFO with registered read port for the transmit path
`timescale 1ns/1ps
module scs_fifo
  import scs_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
    logic [W-1:0] dout;
    logic dv;
    logic rdy;
  } scs_fifo_s;

  scs_fifo_s q_reg;
  scs_fifo_s q_next;
  logic push;
  logic take;
  logic pull;

  // ============================================================
  // Next state
  always_comb begin
    q_next = q_reg;
    push = in_valid && q_reg.rdy;
    take = q_reg.dv && out_ready;
    // Output register refills from memory when empty or being drained
    pull = (q_reg.count != '0) && (!q_reg.dv || take);
    if (push) begin
      q_next.mem[q_reg.wr] = in_data;
      q_next.wr = q_reg.wr + AW'(1);
    end
    if (pull) begin
      q_next.dout = q_reg.mem[q_reg.rd];
      q_next.rd = q_reg.rd + AW'(1);
      q_next.dv = 1'b1;
    end else if (take) begin
      q_next.dv = 1'b0;
    end
    q_next.count = q_reg.count + CW'(push) - CW'(pull);
    q_next.rdy = (q_next.count != CW'(D));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.rdy <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign in_ready = q_reg.rdy;
  assign out_valid = q_reg.dv;
  assign out_data = q_reg.dout;

endmodule : scs_fifo

// ==== scs_ctrl.sv ====
// Serial bus controller: clock prescaler, phase-0 shifting and select delays
`timescale 1ns/1ps
module scs_ctrl
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [31:0] global_control_register,
  input wire logic [31:0] word_format_register,
  input wire logic [31:0] delay_config_register,
  // Transmit words
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic select_hold_flag,
  // Received words
  output logic rx_valid,
  output logic [WORD_W-1:0] rx_data,
  // Serial pins and busy status
  output logic serial_clock_line,
  output logic serial_clock_oe,
  output logic controller_out_line,
  output logic controller_out_oe,
  input wire logic controller_in_line,
  output logic chip_select_n,
  output logic chip_select_oe,
  output logic busy
);

  typedef struct packed {
    scs_state_e st;
    logic [9:0] cnt;
    logic [4:0] bits;
    logic [4:0] len;
    logic [WORD_W-1:0] sh;
    logic hold;
    logic pol;
    logic [7:0] ps;
    logic [7:0] c2t;
    logic [7:0] t2c;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic oe;
    logic [WORD_W-1:0] rx;
    logic rxv;
    logic busy;
  } scs_ctrl_s;

  scs_ctrl_s q_reg;
  scs_ctrl_s q_next;

  // ============================================================
  // Decoding helpers
  function automatic logic [8:0] period_of(input logic [7:0] ps);
    period_of = (ps == 8'h00) ? PS0_PERIOD : (9'(ps) + 9'h001);
  endfunction : period_of

  function automatic logic [8:0] half_hi(input logic [7:0] ps);
    logic [8:0] p;
    p = period_of(ps);
    half_hi = p - (p >> 1);
  endfunction : half_hi

  function automatic logic [8:0] half_lo(input logic [7:0] ps);
    half_lo = period_of(ps) >> 1;
  endfunction : half_lo

  function automatic logic [4:0] len_of(input logic [4:0] f);
    if (f < LEN_MIN) len_of = LEN_MIN;
    else if (f > LEN_MAX) len_of = LEN_MAX;
    else len_of = f;
  endfunction : len_of

  function automatic logic [WORD_W-1:0] mask_of(input logic [4:0] len);
    logic [WORD_W:0] m;
    m = ((WORD_W + 1)'(1) << len) - (WORD_W + 1)'(1);
    mask_of = m[WORD_W-1:0];
  endfunction : mask_of

  // ============================================================
  // FIFO in the transmit path
  logic f_valid;
  logic f_pop;
  logic [FIFO_W-1:0] f_data;

  scs_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({select_hold_flag, tx_data}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  logic ctrl_sel;
  logic pol_in;
  logic [4:0] len_new;
  logic [7:0] c2t_new;
  logic hold_new;

  assign ctrl_sel = global_control_register[CTRL_SEL_BIT];
  assign pol_in = word_format_register[FMT_POL_BIT];
  assign len_new = len_of(word_format_register[FMT_LEN_MSB:FMT_LEN_LSB]);
  assign c2t_new = delay_config_register[DLY_C2T_MSB:DLY_C2T_LSB];
  assign hold_new = f_data[FIFO_W-1];

  // ============================================================
  // Sequencer
  always_comb begin
    q_next = q_reg;
    q_next.rxv = 1'b0;
    q_next.oe = ctrl_sel;
    f_pop = 1'b0;
    case (q_reg.st)
      ST_IDLE: begin
        q_next.sclk = pol_in;
        q_next.cs_n = 1'b1;
        f_pop = ctrl_sel && f_valid;
      end
      ST_SETUP: begin
        if (q_reg.cnt == 10'h000) begin
          q_next.sclk = ~q_reg.pol;
          q_next.sh = {q_reg.sh[WORD_W-2:0], controller_in_line};
          q_next.bits = q_reg.bits + 5'h01;
          q_next.cnt = 10'(half_hi(q_reg.ps)) - 10'h001;
          q_next.st = ST_SHIFT;
        end else begin
          q_next.cnt = q_reg.cnt - 10'h001;
        end
      end
      ST_SHIFT: begin
        if (q_reg.cnt != 10'h000) begin
          q_next.cnt = q_reg.cnt - 10'h001;
        end else if (q_reg.sclk != q_reg.pol) begin
          q_next.sclk = q_reg.pol;
          if (q_reg.bits == q_reg.len) begin
            q_next.rx = q_reg.sh & mask_of(q_reg.len);
            q_next.rxv = 1'b1;
            if (q_reg.hold) begin
              q_next.st = ST_KEEP;
            end else begin
              q_next.cnt = 10'(half_lo(q_reg.ps)) + 10'(q_reg.t2c) + DESEL_ADD - 10'h001;
              q_next.st = ST_HOLD;
            end
          end else begin
            // Next bit leaves on the trailing edge, half a period before capture
            q_next.mosi = q_reg.sh[WORD_W-1];
            q_next.cnt = 10'(half_lo(q_reg.ps)) - 10'h001;
          end
        end else begin
          q_next.sclk = ~q_reg.pol;
          q_next.sh = {q_reg.sh[WORD_W-2:0], controller_in_line};
          q_next.bits = q_reg.bits + 5'h01;
          q_next.cnt = 10'(half_hi(q_reg.ps)) - 10'h001;
        end
      end
      ST_HOLD: begin
        if (q_reg.cnt == 10'h000) begin
          q_next.cs_n = 1'b1;
          q_next.st = ST_IDLE;
        end else begin
          q_next.cnt = q_reg.cnt - 10'h001;
        end
      end
      ST_KEEP: begin
        // Select is held low until the next word or loss of controller role
        if (!ctrl_sel) begin
          q_next.cs_n = 1'b1;
          q_next.st = ST_IDLE;
        end else begin
          f_pop = f_valid;
        end
      end
      default: begin
        q_next.st = ST_IDLE;
        q_next.cs_n = 1'b1;
      end
    endcase
    if (f_pop) begin
      // Each word latches its own format at its start
      q_next.len = len_new;
      q_next.sh = f_data[WORD_W-1:0] << (5'(WORD_W) - len_new);
      q_next.mosi = q_next.sh[WORD_W-1];
      q_next.hold = hold_new;
      q_next.pol = pol_in;
      q_next.sclk = pol_in;
      q_next.ps = word_format_register[FMT_PS_MSB:FMT_PS_LSB];
      q_next.c2t = c2t_new;
      q_next.t2c = delay_config_register[DLY_T2C_MSB:DLY_T2C_LSB];
      q_next.cnt = 10'(c2t_new) + (hold_new ? SETUP_ADD_HOLD : SETUP_ADD) - 10'h001;
      q_next.bits = 5'h00;
      q_next.cs_n = 1'b0;
      q_next.st = ST_SETUP;
    end
    q_next.busy = (q_next.st != ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.cs_n <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign serial_clock_line = q_reg.sclk;
  assign serial_clock_oe = q_reg.oe;
  assign controller_out_line = q_reg.mosi;
  assign controller_out_oe = q_reg.oe;
  assign chip_select_n = q_reg.cs_n;
  assign chip_select_oe = q_reg.oe;
  assign rx_valid = q_reg.rxv;
  assign rx_data = q_reg.rx;
  assign busy = q_reg.busy;

  // ============================================================
  // Checks
  logic sclk_d;
  logic [9:0] gap;
  logic [9:0] setup_age;
  logic [9:0] hold_age;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      gap <= 10'h000;
      setup_age <= 10'h000;
      hold_age <= 10'h000;
    end else begin
      sclk_d <= q_reg.sclk;
      gap <= (q_reg.sclk != sclk_d) ? 10'h001 : gap + 10'h001;
      setup_age <= (q_reg.st == ST_SETUP) ? setup_age + 10'h001 : 10'h000;
      hold_age <= (q_reg.st == ST_HOLD) ? hold_age + 10'h001 : 10'h000;
    end
  end

  default clocking scs_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence leave_setup_s;
    (q_reg.st == ST_SHIFT) && ($past(q_reg.st) == ST_SETUP);
  endsequence

  sequence leave_hold_s;
    (q_reg.st == ST_IDLE) && ($past(q_reg.st) == ST_HOLD);
  endsequence

  controller_enable_a: assert property (ctrl_sel |=> serial_clock_oe && chip_select_oe)
    else $error("pins not driven in controller role");
  idle_clock_level_a: assert property ((q_reg.st == ST_IDLE) ##1 (q_reg.st == ST_IDLE)
    |-> serial_clock_line == $past(pol_in))
    else $error("idle clock level wrong");
  active_half_a: assert property (($past(q_reg.st) == ST_SHIFT) && (q_reg.sclk != sclk_d)
    && (q_reg.sclk == q_reg.pol) |-> gap == 10'(half_hi(q_reg.ps)))
    else $error("active half length wrong");
  idle_half_a: assert property ((q_reg.st == ST_SHIFT) && (q_reg.sclk != sclk_d)
    && (q_reg.sclk != q_reg.pol) && (q_reg.bits > 5'h01)
    |-> gap == 10'(half_lo(q_reg.ps)))
    else $error("idle half length wrong");
  select_setup_a: assert property (leave_setup_s |-> ($past(setup_age) + 10'h001)
    == 10'(q_reg.c2t) + (q_reg.hold ? SETUP_ADD_HOLD : SETUP_ADD))
    else $error("select to clock delay wrong");
  deselect_hold_a: assert property (leave_hold_s |-> ($past(hold_age) + 10'h001)
    == 10'(half_lo(q_reg.ps)) + 10'(q_reg.t2c) + DESEL_ADD)
    else $error("clock to deselect delay wrong");
  data_out_edge_a: assert property (($past(q_reg.st) == ST_SHIFT) && $changed(q_reg.mosi)
    |-> (q_reg.sclk != sclk_d) && (q_reg.sclk == q_reg.pol))
    else $error("data out moved off trailing edge");
  capture_edge_a: assert property ((q_reg.st == ST_SHIFT) && (q_reg.sclk != sclk_d)
    && (q_reg.sclk != q_reg.pol) |-> q_reg.sh[0] == $past(controller_in_line))
    else $error("data in not captured on active edge");
  word_length_a: assert property (q_reg.rxv |-> (q_reg.bits == q_reg.len)
    && (q_reg.len >= LEN_MIN) && (q_reg.len <= LEN_MAX))
    else $error("word bit count wrong");
  select_keep_a: assert property ((q_reg.st == ST_KEEP) |-> !chip_select_n)
    else $error("select released while held");

endmodule : scs_ctrl

// ==== scs_periph.sv ====
// Behavioural peripheral on the far side of the serial controller
`timescale 1ns/1ps
module scs_periph (
  // Serial pins
  input wire logic serial_clock_line,
  input wire logic controller_out_line,
  input wire logic chip_select_n,
  output logic controller_in_line,
  // Setup and capture
  input wire logic pol,
  input wire logic [4:0] len,
  input wire logic [15:0] reply,
  output logic [15:0] got
);
  logic [15:0] sh = 16'h0000;
  int bc = 0;
  initial controller_in_line = 1'b0;
  initial got = 16'h0000;
  // ============================================================
  // Shifting
  always @(negedge chip_select_n) begin
    sh = reply << (5'h10 - len);
    bc = 0;
    controller_in_line = sh[15];
  end
  // Released line flips so a stale bit is never mistaken for data
  always @(posedge chip_select_n) controller_in_line = ~controller_in_line;
  always @(serial_clock_line) begin
    if (!chip_select_n && serial_clock_line != pol) begin
      got = {got[14:0], controller_out_line};
    end else if (!chip_select_n) begin
      bc++;
      sh = (bc == len) ? reply << (5'h10 - len) : sh << 1;
      bc = (bc == len) ? 0 : bc;
      controller_in_line = sh[15];
    end
  end
endmodule : scs_periph

// ==== scs_ctrl_test.sv ====
// Self-checking bench of the serial controller timing block
`timescale 1ns/1ps
module scs_ctrl_test;
  import scs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] global_control_register = 32'h00000000;
  logic [31:0] word_format_register = 32'h00000008;
  logic [31:0] delay_config_register = 32'h00000000;
  logic tx_valid = 1'b0;
  logic [WORD_W-1:0] tx_data = 16'h0000;
  logic select_hold_flag = 1'b0;
  logic tx_ready, rx_valid, serial_clock_line, serial_clock_oe, controller_out_line;
  logic controller_out_oe, controller_in_line, chip_select_n, chip_select_oe, busy;
  logic [WORD_W-1:0] rx_data;
  logic [4:0] len = 5'h08;
  logic [15:0] reply = 16'h0000;
  logic [15:0] got;
  int errors = 0;
  int n_compared = 0;

  scs_ctrl dut (.core_clk, .rst_n, .global_control_register, .word_format_register,
    .delay_config_register, .tx_valid, .tx_ready, .tx_data, .select_hold_flag, .rx_valid,
    .rx_data, .serial_clock_line, .serial_clock_oe, .controller_out_line, .controller_out_oe,
    .controller_in_line, .chip_select_n, .chip_select_oe, .busy);
  scs_periph model (.serial_clock_line, .controller_out_line, .chip_select_n,
    .controller_in_line, .pol(word_format_register[17]), .len, .reply, .got);

  // ============================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic push(input logic [15:0] d, input logic h);
    tx_valid <= 1'b1;
    tx_data <= d;
    select_hold_flag <= h;
    for (int i = 0; i < 50; i++) begin
      @(posedge core_clk);
      // Valid stays up so a second word follows without a gap; caller drops it
      if (tx_ready === 1'b1) return;
    end
    errors++;
    end_of_test;
  endtask : push

  // ============================================================
  // Scenarios
  // One word (two when held), timing measured edge by edge at the pins
  task automatic word(input logic pl, input logic [7:0] pre, c2t, t2c, input logic [4:0] ln,
                      input logic h, input logic [15:0] d, r);
    int p, cyc, t_cs, t_act, t_trail, t_rx, nact;
    logic pc, sc;
    logic [15:0] mask;
    @(posedge core_clk);
    p = (pre == 0) ? 2 : pre + 1;
    mask = 16'hFFFF >> (16 - ln);
    word_format_register <= {14'h0000, pl, 1'b0, pre, 3'h0, ln};
    delay_config_register <= {c2t, t2c, 16'h0000};
    global_control_register <= 32'h00000001;
    len <= ln;
    reply <= r;
    repeat (3) @(posedge core_clk);
    push(d, h);
    if (h) push(d, 1'b0);
    tx_valid <= 1'b0;
    pc = 1'b1;
    sc = pl;
    nact = 0;
    t_cs = 0;
    t_act = 0;
    t_trail = 0;
    t_rx = 0;
    for (cyc = 1; cyc < 3000; cyc++) begin
      @(posedge core_clk);
      #1;
      if (rx_valid === 1'b1) t_rx = cyc;
      if (pc && !chip_select_n) begin
        t_cs = cyc;
        chk("busy start", 1, busy);
      end
      if (serial_clock_line !== sc && serial_clock_line !== pl) begin
        nact++;
        if (nact == 1) chk("setup", c2t + 2 + h, cyc - t_cs);
        else if ((nact - 1) % ln != 0) chk("idle half", p / 2, cyc - t_trail);
        t_act = cyc;
      end
      if (serial_clock_line !== sc && serial_clock_line === pl) begin
        chk("active half", p - p / 2, cyc - t_act);
        t_trail = cyc;
      end
      if (!pc && chip_select_n) break;
      pc = chip_select_n;
      sc = serial_clock_line;
    end
    if (cyc >= 3000) begin
      errors++;
      end_of_test;
    end
    chk("edges", (h ? 2 : 1) * ln, nact);
    chk("rx time", t_trail, t_rx);
    chk("deselect", p / 2 + t2c + 1, cyc - t_trail);
    chk("rx data", r & mask, rx_data);
    chk("tx data", d & mask, got & mask);
    chk("idle level", pl, serial_clock_line);
    chk("busy end", 0, busy);
  endtask : word

  // Buffer filled while the controller role is off, then drained
  task automatic fill_drain;
    int n, k, i;
    @(posedge core_clk);
    n = 0;
    k = 0;
    global_control_register <= 32'h00000000;
    // Length field below the minimum, so each word is clamped to two bits
    word_format_register <= 32'h00000001;
    len <= 5'h02;
    reply <= 16'h0001;
    tx_valid <= 1'b1;
    tx_data <= 16'h0002;
    select_hold_flag <= 1'b0;
    repeat (40) begin
      @(posedge core_clk);
      if (tx_ready === 1'b1) n++;
    end
    tx_valid <= 1'b0;
    chk("fill count", 17, n);
    chk("no select", 1, chip_select_n);
    chk("clock oe off", 0, serial_clock_oe);
    chk("data oe off", 0, controller_out_oe);
    chk("select oe off", 0, chip_select_oe);
    global_control_register <= 32'h00000001;
    for (i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      #1;
      if (rx_valid === 1'b1) k++;
      if (k == 17 && busy === 1'b0) break;
    end
    if (i >= 2000) begin
      errors++;
      end_of_test;
    end
    chk("drained", 17, k);
    chk("clock oe on", 1, serial_clock_oe);
    chk("data oe on", 1, controller_out_oe);
    chk("select oe on", 1, chip_select_oe);
    chk("clamped rx", 16'h0001, rx_data);
    chk("clamped tx", 16'h0002, got & 16'h0003);
    chk("ready", 1, tx_ready);
  endtask : fill_drain

  // ============================================================
  // Main sequence
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("reset select", 1, chip_select_n);
    chk("reset ready", 1, tx_ready);
    chk("reset clock", 0, serial_clock_line);
    word(1'b0, 8'h01, 8'h00, 8'h00, 5'h08, 1'b0, 16'h00A5, 16'h003C);
    word(1'b1, 8'h00, 8'h03, 8'h02, 5'h10, 1'b0, 16'hC3A5, 16'h5A0F);
    word(1'b0, 8'h04, 8'h01, 8'h00, 5'h02, 1'b1, 16'h0002, 16'h0001);
    word(1'b1, 8'h02, 8'h00, 8'h05, 5'h05, 1'b1, 16'h0016, 16'h0009);
    fill_drain;
    end_of_test;
  end
endmodule : scs_ctrl_test
